// ==== lscx_core.sv ====
// Overview of operation
// - Checked add sums 33-bit sign-extended operands; top bits differing traps, no write.
// - Multi-byte objects are addressed by their lowest byte address, any ordering.
// - Addressed byte is most significant when big-endian, least when little-endian.
// - Active bytes come from length code plus two or three low address bits.
// - Coprocessor load word sends a 32-bit word and register specifier to the unit.
// - Coprocessor load doubleword sends a 64-bit value and register specifier.
// - Coprocessor operation forwards the function field to the selected unit.
// - Translation takes address, fetch/data and load/store; gives physical and attribute.
// - Unmapped regions derive physical address and attribute straight from the address.
// - Mapped regions use the lookup; a miss or forbidden access faults.
// - Length code is byte count minus one, 0 to 7.
`timescale 1ns/1ps
`default_nettype none
`include "lscx_cfg.svh"
module lscx_core #(
   parameter int MAP_ENTRIES = 4
) (
   input wire logic clk_sys,
   input wire logic rstn,
   // Checked / wraparound add
   input wire logic add_valid,
   input wire logic add_checked,
   input wire logic [31:0] add_a,
   input wire logic [31:0] add_b,
   output logic [$bits(lscx_pkg::lscx_add_rsp_t)-1:0] add_rsp,
   // Translation
   input wire logic [$bits(lscx_pkg::lscx_xlate_req_t)-1:0] xlate_req,
   output logic [$bits(lscx_pkg::lscx_xlate_rsp_t)-1:0] xlate_rsp,
   // Mapping table entries, written through these ports whenever map_wr is high
   input wire logic map_wr,
   input wire logic [1:0] map_idx,
   input wire logic [19:0] map_vpn,
   input wire logic [19:0] map_pfn,
   input wire logic map_writable,
   input wire logic map_fetchable,
   input wire logic [2:0] map_cca,
   // Coprocessor command from the pipeline
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic [1:0] cmd_unit,
   input wire logic [4:0] cmd_reg_select,
   input wire logic [63:0] cmd_data,
   input wire logic [24:0] cmd_function_code,
   output logic cmd_ready,
   // Coprocessor side
   output logic [$bits(lscx_pkg::lscx_cop_req_t)-1:0] cop_req,
   input wire logic cop_ack,
   input wire logic [63:0] cop_store_data,
   output logic store_valid,
   output logic [63:0] store_data
);
   import lscx_pkg::*;

   typedef struct packed {
      logic [MAP_ENTRIES-1:0] map_valid;
      logic [MAP_ENTRIES-1:0][19:0] map_vpn_tab;
      logic [MAP_ENTRIES-1:0][19:0] map_pfn_tab;
      logic [MAP_ENTRIES-1:0] map_w;
      logic [MAP_ENTRIES-1:0] map_x;
      logic [MAP_ENTRIES-1:0][2:0] map_attr;
      lscx_add_rsp_t add_o;
      lscx_xlate_rsp_t xl_o;
      lscx_cop_req_t cop_o;
      logic busy;
      logic idle;
      logic st_valid;
      logic [63:0] st_data;
   } lscx_state_t;

   lscx_state_t state;
   lscx_state_t next_state;
   lscx_xlate_req_t xr;
   lscx_op_t op_in;
   logic [32:0] temp;
   logic [MAP_ENTRIES-1:0] hit_vec;
   logic [MAP_ENTRIES-1:0] ok_vec;

   assign xr = lscx_xlate_req_t'(xlate_req);
   assign op_in = lscx_op_t'(cmd_op);

   // Byte lanes: lowest address names the object; big-endian mirrors lanes
   function automatic logic [7:0] lane_mask(input logic [2:0] len, input logic [2:0] lo,
                                            input logic be, input logic dbl);
      logic [7:0] m;
      logic [3:0] first;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         first = {1'b0, i[2:0]} - {1'b0, lo};
         if (i[2:0] >= lo && first <= {1'b0, len}) begin
            m[i] = 1'b1;
         end
      end
      if (!dbl) begin
         m[7:4] = 4'h0;
         if (be) begin
            m[3:0] = {m[0], m[1], m[2], m[3]};
         end
      end else if (be) begin
         m = {m[0], m[1], m[2], m[3], m[4], m[5], m[6], m[7]};
      end
      return m;
   endfunction

   assign temp = {add_a[31], add_a} + {add_b[31], add_b};

   genvar g;
   generate
      for (g = 0; g < MAP_ENTRIES; g++) begin : g_map
         assign hit_vec[g] = state.map_valid[g] &&
                             state.map_vpn_tab[g] == xr.virtual_location[31:`LSCX_MAP_PAGE_BITS];
         assign ok_vec[g] = (!xr.load_or_store_select || state.map_w[g]) &&
                            (xr.fetch_or_data_select || state.map_x[g]);
      end
   endgenerate

   always_comb begin
      logic [2:0] seg;
      logic [2:0] lo;
      seg = xr.virtual_location[31:29];
      lo = xr.double_unit ? xr.virtual_location[2:0] : {1'b0, xr.virtual_location[1:0]};
      next_state = state;
      if (map_wr) begin
         next_state.map_valid[map_idx] = 1'b1;
         next_state.map_vpn_tab[map_idx] = map_vpn;
         next_state.map_pfn_tab[map_idx] = map_pfn;
         next_state.map_w[map_idx] = map_writable;
         next_state.map_x[map_idx] = map_fetchable;
         next_state.map_attr[map_idx] = map_cca;
      end
      next_state.add_o.valid = add_valid;
      next_state.add_o.sum = temp[31:0];
      next_state.add_o.overflow_trap = add_valid && add_checked && (temp[32] != temp[31]);
      next_state.add_o.write_dest = add_valid && !(add_checked && (temp[32] != temp[31]));
      next_state.xl_o = '0;
      next_state.xl_o.valid = xr.valid;
      next_state.xl_o.byte_enable = lane_mask(xr.transfer_byte_count_code, lo,
                                              xr.big_endian, xr.double_unit);
      if (seg >= `LSCX_UNMAP_LO && seg <= `LSCX_UNMAP_HI) begin
         // Unmapped windows: strip the segment bits, attribute by window
         next_state.xl_o.phys_location = xr.virtual_location & `LSCX_PHYS_MASK;
         next_state.xl_o.cache_coherency_attribute = (seg == `LSCX_UNMAP_CACHED) ?
            `LSCX_CCA_CACHED : `LSCX_CCA_UNCACHED;
      end else begin
         next_state.xl_o.fault = xr.valid && ((hit_vec & ok_vec) == '0);
         for (int i = 0; i < MAP_ENTRIES; i++) begin
            if (hit_vec[i]) begin
               next_state.xl_o.phys_location = {state.map_pfn_tab[i],
                  xr.virtual_location[`LSCX_MAP_PAGE_BITS-1:0]};
               next_state.xl_o.cache_coherency_attribute = state.map_attr[i];
            end
         end
         if (next_state.xl_o.fault) begin
            next_state.xl_o.byte_enable = 8'h00;
         end
      end
      next_state.st_valid = 1'b0;
      if (state.busy) begin
         if (cop_ack) begin
            next_state.busy = 1'b0;
            next_state.cop_o.valid = 1'b0;
            if (state.cop_o.op == lscx_op_word_out) begin
               next_state.st_valid = 1'b1;
               next_state.st_data = {32'h0, cop_store_data[31:0]};
            end else if (state.cop_o.op == lscx_op_double_out) begin
               next_state.st_valid = 1'b1;
               next_state.st_data = cop_store_data;
            end
         end
      end else if (state.idle && cmd_valid && op_in != lscx_op_none) begin
         next_state.busy = 1'b1;
         next_state.cop_o.valid = 1'b1;
         next_state.cop_o.op = op_in;
         next_state.cop_o.unit = cmd_unit;
         next_state.cop_o.reg_select = cmd_reg_select;
         next_state.cop_o.function_code = (op_in == lscx_op_function) ? cmd_function_code : 25'h0;
         unique case (op_in)
            lscx_op_word_in: next_state.cop_o.data = {32'h0, cmd_data[31:0]};
            lscx_op_double_in: next_state.cop_o.data = cmd_data;
            default: next_state.cop_o.data = 64'h0;
         endcase
      end
      // Ready is its own flop so the port never sees a gate; low until the first edge after reset
      next_state.idle = !next_state.busy;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign add_rsp = state.add_o;
   assign xlate_rsp = state.xl_o;
   assign cop_req = state.cop_o;
   assign cmd_ready = state.idle;
   assign store_valid = state.st_valid;
   assign store_data = state.st_data;
endmodule
`default_nettype wire

// ==== lscx_cfg.svh ====
`ifndef LSCX_CFG_SVH
`define LSCX_CFG_SVH
`define LSCX_LEN_BYTE 3'h0
`define LSCX_LEN_HALF 3'h1
`define LSCX_LEN_WORD 3'h3
`define LSCX_LEN_DOUBLE 3'h7
`define LSCX_SEG_HI 3'h7
`define LSCX_UNMAP_LO 3'h4
`define LSCX_UNMAP_HI 3'h5
`define LSCX_UNMAP_CACHED 3'h4
`define LSCX_CCA_CACHED 3'h3
`define LSCX_CCA_UNCACHED 3'h2
`define LSCX_PHYS_MASK 32'h1FFFFFFF
`define LSCX_MAP_PAGE_BITS 12
`endif

// ==== lscx_pkg.sv ====
package lscx_pkg;
   typedef enum logic [2:0] {
      lscx_op_none,
      lscx_op_word_in,
      lscx_op_double_in,
      lscx_op_word_out,
      lscx_op_double_out,
      lscx_op_function
   } lscx_op_t;

   typedef struct packed {
      logic valid;
      lscx_op_t op;
      logic [1:0] unit;
      logic [4:0] reg_select;
      logic [63:0] data;
      logic [24:0] function_code;
   } lscx_cop_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] virtual_location;
      logic fetch_or_data_select;
      logic load_or_store_select;
      logic [2:0] transfer_byte_count_code;
      logic big_endian;
      logic double_unit;
   } lscx_xlate_req_t;

   typedef struct packed {
      logic valid;
      logic fault;
      logic [31:0] phys_location;
      logic [2:0] cache_coherency_attribute;
      logic [7:0] byte_enable;
   } lscx_xlate_rsp_t;

   typedef struct packed {
      logic valid;
      logic [31:0] sum;
      logic overflow_trap;
      logic write_dest;
   } lscx_add_rsp_t;
endpackage

// ==== lscx_core_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module lscx_core_asserts
import lscx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic add_valid,
   input wire logic add_checked,
   input wire logic [31:0] add_a,
   input wire logic [31:0] add_b,
   input wire logic [$bits(lscx_pkg::lscx_add_rsp_t)-1:0] add_rsp,
   input wire logic [$bits(lscx_pkg::lscx_xlate_req_t)-1:0] xlate_req,
   input wire logic [$bits(lscx_pkg::lscx_xlate_rsp_t)-1:0] xlate_rsp,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [2:0] cmd_op,
   input wire logic [1:0] cmd_unit,
   input wire logic [4:0] cmd_reg_select,
   input wire logic [$bits(lscx_pkg::lscx_cop_req_t)-1:0] cop_req,
   input wire logic cop_ack,
   input wire logic [63:0] cop_store_data,
   input wire logic store_valid,
   input wire logic [63:0] store_data
);
   lscx_add_rsp_t ar;
   lscx_xlate_req_t xq;
   lscx_xlate_rsp_t xs;
   lscx_cop_req_t cq;
   logic [32:0] s;
   assign ar = add_rsp;
   assign xq = xlate_req;
   assign xs = xlate_rsp;
   assign cq = cop_req;
   assign s = {add_a[31], add_a} + {add_b[31], add_b};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   add_sum_a: assert property (add_valid |=> ar.valid && ar.sum == $past(s[31:0]))
      else $error("add sum wrong");
   add_trap_a: assert property (add_valid && add_checked && s[32] != s[31] |=> ar.overflow_trap && !ar.write_dest)
      else $error("overflow not trapped");
   wrap_write_a: assert property (add_valid && !add_checked |=> ar.write_dest && !ar.overflow_trap)
      else $error("wraparound add trapped");
   xlate_answer_a: assert property (xq.valid |=> xs.valid)
      else $error("translation unanswered");
   unmapped_xlate_a: assert property (xq.valid && xq.virtual_location[31:30] == 2'b10 |=> !xs.fault
      && xs.phys_location == ($past(xq.virtual_location) & 32'h1FFFFFFF)
      && xs.cache_coherency_attribute == ($past(xq.virtual_location[29]) ? 3'h2 : 3'h3)) else $error("unmapped wrong");
   fault_lanes_a: assert property (xs.fault |-> xs.byte_enable == 8'h00)
      else $error("faulted access has lanes");
   cmd_take_a: assert property (cmd_valid && cmd_ready && cmd_op != 3'h0 |=> cq.valid
      && cq.unit == $past(cmd_unit) && cq.reg_select == $past(cmd_reg_select)) else $error("command not sent");
   cop_hold_a: assert property (cq.valid && !cop_ack |=> $stable(cop_req))
      else $error("request moved before ack");
   cop_drop_a: assert property (cq.valid && cop_ack |=> !cq.valid && cmd_ready)
      else $error("request stayed after ack");
   word_store_a: assert property (cq.valid && cop_ack && cq.op == lscx_op_word_out |=> store_valid
      && store_data[31:0] == $past(cop_store_data[31:0])) else $error("word store wrong");
   dbl_store_a: assert property (cq.valid && cop_ack && cq.op == lscx_op_double_out |=> store_valid
      && store_data == $past(cop_store_data)) else $error("double store wrong");
   cover property (add_valid && add_checked && s[32] != s[31]);
   cover property (xs.valid && xs.fault);
   cover property (cq.valid && cop_ack);
endmodule
`default_nettype wire

// ==== lscx_cop_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lscx_cop_model
import lscx_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [$bits(lscx_pkg::lscx_cop_req_t)-1:0] cop_req,
   input wire logic [3:0] lag,
   output logic cop_ack,
   output var logic [63:0] cop_store_data
);
   lscx_cop_req_t q;
   logic [3:0] n;
   logic [63:0] v;
   assign q = cop_req;
   // Register contents stand in as a pattern tied to the specifier
   assign v = {2{27'h5A5A5A5, q.reg_select}};
   // Inverted off the ack so stale data never passes for fresh
   assign cop_store_data = cop_ack ? v : ~v;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         n <= 4'h0;
         cop_ack <= 1'b0;
      end else begin
         cop_ack <= q.valid && !cop_ack && n == lag;
         n <= (q.valid && !cop_ack && n != lag) ? n + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// ==== test_lscx.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_lscx;
   import lscx_pkg::*;
   logic clk_sys = 0, rstn = 0, add_valid = 0, add_checked = 0, map_wr = 0, map_writable = 0, map_fetchable = 1;
   logic cmd_valid = 0, cop_ack, store_valid, cmd_ready;
   logic [31:0] add_a = 0, add_b = 0;
   logic [1:0] map_idx = 0, cmd_unit = 0;
   logic [19:0] map_vpn = 20'h00400, map_pfn = 20'h12345;
   logic [2:0] map_cca = 3'h3, cmd_op = 0;
   logic [4:0] cmd_reg_select = 0;
   logic [63:0] cmd_data = 0, cop_store_data, store_data;
   logic [24:0] cmd_function_code = 0;
   logic [3:0] lag = 0;
   lscx_add_rsp_t ar;
   lscx_xlate_req_t xq = '0;
   lscx_xlate_rsp_t xs;
   lscx_cop_req_t cq;
   int bad_count = 0, compares = 0;
   always #5 clk_sys = ~clk_sys;
   lscx_core i_lscx_core(.*, .add_rsp(ar), .xlate_req(xq), .xlate_rsp(xs), .cop_req(cq));
   lscx_cop_model i_lscx_cop_model(.*, .cop_req(cq));
   task automatic close_out();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic do_add(logic c, logic [31:0] a, logic [31:0] b);
      logic [32:0] s;
      s = {a[31], a} + {b[31], b};
      add_valid = 1;
      add_checked = c;
      add_a = a;
      add_b = b;
      @(negedge clk_sys);
      `CK("sum", s[31:0], ar.sum)
      `CK("trap", c & (s[32] ^ s[31]), ar.overflow_trap)
      `CK("write", !(c & (s[32] ^ s[31])), ar.write_dest)
   endtask
   task automatic do_xl(logic [31:0] va, logic ls, logic [2:0] len, logic big, logic dbl, logic f,
                        logic [31:0] ph, logic [2:0] cc, logic [7:0] be);
      xq = '{1'b1, va, 1'b1, ls, len, big, dbl};
      @(negedge clk_sys);
      `CK("fault", f, xs.fault)
      `CK("lanes", be, xs.byte_enable)
      if (!f) begin `CK("phys", ph, xs.phys_location) `CK("cca", cc, xs.cache_coherency_attribute) end
   endtask
   task automatic do_cop(lscx_op_t op, logic [3:0] l);
      logic [4:0] r;
      r = {2'h0, op} + 5'h3;
      lag = l;
      cmd_valid = 1;
      cmd_op = op;
      cmd_unit = op[1:0];
      cmd_reg_select = r;
      cmd_data = {16{op, 1'b1}};
      cmd_function_code = {5{op, 2'b10}};
      @(negedge clk_sys);
      cmd_reg_select = 5'h1F;
      `CK("unit", op[1:0], cq.unit)
      `CK("op", op, cq.op)
      if (op == lscx_op_word_in) `CK("dw", cmd_data[31:0], cq.data[31:0])
      if (op == lscx_op_double_in) `CK("dd", cmd_data, cq.data)
      if (op == lscx_op_function) `CK("fn", cmd_function_code, cq.function_code)
      `CK("busy", 1'b0, cmd_ready)
      @(negedge clk_sys);
      cmd_valid = 0;
      `CK("hold", r, cq.reg_select)
      for (int i = 0; i < 20 && !cop_ack; i++) @(negedge clk_sys);
      if (!cop_ack) begin
         bad_count++;
         close_out();
      end
      @(negedge clk_sys);
      `CK("stv", op == lscx_op_word_out || op == lscx_op_double_out, store_valid)
      if (op == lscx_op_word_out) `CK("sw", {27'h5A5A5A5, r}, store_data[31:0])
      if (op == lscx_op_double_out) `CK("sd", {2{27'h5A5A5A5, r}}, store_data)
      `CK("idle", 1'b1, cmd_ready)
   endtask
   initial begin
      repeat (2) @(negedge clk_sys);
      rstn = 1;
      do_add(1, 32'h00000005, 32'hFFFFFFFD);
      do_add(1, 32'h7FFFFFFF, 32'h00000001);
      do_add(0, 32'h7FFFFFFF, 32'h00000001);
      do_add(1, 32'h80000000, 32'hFFFFFFFF);
      add_valid = 0;
      do_xl(32'h80001234, 0, 3'h3, 0, 0, 0, 32'h00001234, 3'h3, 8'h0F);
      do_xl(32'hA0000002, 0, 3'h1, 0, 0, 0, 32'h00000002, 3'h2, 8'h0C);
      do_xl(32'hA0000002, 0, 3'h1, 1, 0, 0, 32'h00000002, 3'h2, 8'h03);
      do_xl(32'h80000001, 0, 3'h2, 0, 0, 0, 32'h00000001, 3'h3, 8'h0E);
      do_xl(32'h80000004, 1, 3'h3, 0, 1, 0, 32'h00000004, 3'h3, 8'hF0);
      do_xl(32'h80000007, 0, 3'h0, 1, 1, 0, 32'h00000007, 3'h3, 8'h01);
      do_xl(32'h00400678, 0, 3'h3, 0, 0, 1, 32'h0, 3'h0, 8'h00);
      map_wr = 1;
      @(negedge clk_sys);
      map_wr = 0;
      do_xl(32'h00400678, 0, 3'h3, 0, 0, 0, 32'h12345678, 3'h3, 8'h0F);
      do_xl(32'h00400678, 1, 3'h3, 0, 0, 1, 32'h0, 3'h0, 8'h00);
      do_cop(lscx_op_word_in, 4'h0);
      do_cop(lscx_op_double_in, 4'h3);
      do_cop(lscx_op_word_out, 4'h1);
      do_cop(lscx_op_double_out, 4'h2);
      do_cop(lscx_op_function, 4'h0);
      close_out();
   end
endmodule
bind lscx_core lscx_core_asserts i_lscx_core_asserts(.*);
`default_nettype wire
